/* rtl/qdc_top.sv */
module qdc_top (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         start_i,
   input  wire logic         stop_i,
   input  wire logic         byte_valid_i,
   input  wire logic [7:0]   byte_i,
   input  wire logic [6:0]   own_addr_i,
   input  wire logic         load_outputs_n_i,
   output logic              ack_o,
   output logic [63:0]       dac_code_o,
   output logic [63:0]       input_code_o,
   output logic [3:0]        load_mask_o,
   output logic [7:0]        power_mode_o,
   output logic              reference_on_o,
   output logic              soft_reset_o,
   output logic [2:0]        last_cmd_o
);
   // ==========================================
   // Frame sequencer states
   typedef enum logic [4:0] {
      QDC_IDLE  = 5'b00001,
      QDC_CMD   = 5'b00010,
      QDC_HIGH  = 5'b00100,
      QDC_LOW   = 5'b01000,
      QDC_SKIP  = 5'b10000
   } qdc_state_t;

   qdc_state_t  state_q;
   logic [7:0]  cmd_q;
   logic [7:0]  high_q;
   logic        block_done;
   logic [23:0] word;
   logic [2:0]  cmd;
   logic [2:0]  sel;
   logic [3:0]  sel_mask;
   logic        addr_hit;
   logic [3:0]  wr_vec;
   logic [3:0]  upd_vec;
   logic [3:0]  fresh_vec;
   logic        load_low;

   // ==========================================
   // Address match, own or broadcast, writes only
   assign addr_hit = !byte_i[0] &&
                     ((byte_i[7:1] == own_addr_i) ||
                      (byte_i[7:1] == qdc_pkg::BCAST_ADDR));

   // Acknowledge for each accepted byte
   assign ack_o = byte_valid_i && !stop_i && !start_i &&
                  ((state_q == QDC_IDLE) ? addr_hit : (state_q != QDC_SKIP));

   // Sequencer: address, command, high, low, then repeat
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= QDC_IDLE;
      end else if (stop_i) begin
         state_q <= QDC_IDLE;
      end else if (start_i) begin
         state_q <= QDC_IDLE;
      end else if (byte_valid_i) begin
         case (state_q)
            QDC_IDLE: begin
               state_q <= addr_hit ? QDC_CMD : QDC_SKIP;
            end
            QDC_CMD: begin
               state_q <= QDC_HIGH;
            end
            QDC_HIGH: begin
               state_q <= QDC_LOW;
            end
            QDC_LOW: begin
               if (cmd_q[qdc_pkg::BIT_BYTEMODE - 16]) begin
                  state_q <= QDC_HIGH;
               end else begin
                  state_q <= QDC_CMD;
               end
            end
            QDC_SKIP: begin
               state_q <= QDC_SKIP;
            end
            default: begin
               state_q <= QDC_IDLE;
            end
         endcase
      end
   end

   // Command byte capture, kept for byte-mode reuse
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmd_q <= 8'h00;
      end else if (byte_valid_i && !stop_i && !start_i && state_q == QDC_CMD) begin
         cmd_q <= byte_i;
      end
   end

   // High data byte capture
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         high_q <= 8'h00;
      end else if (byte_valid_i && !stop_i && !start_i && state_q == QDC_HIGH) begin
         high_q <= byte_i;
      end
   end

   // ==========================================
   // Word assembly and decode on last byte of block
   assign block_done = byte_valid_i && !stop_i && !start_i &&
                       (state_q == QDC_LOW);
   assign word = {cmd_q, high_q, byte_i};
   assign cmd  = word[qdc_pkg::CMD_HI:qdc_pkg::CMD_LO];
   assign sel  = word[qdc_pkg::SEL_HI:qdc_pkg::SEL_LO];

   // Channel select decode
   always_comb begin
      sel_mask = 4'h0;
      case (sel)
         3'h0: sel_mask = 4'h1;
         3'h1: sel_mask = 4'h2;
         3'h2: sel_mask = 4'h4;
         3'h3: sel_mask = 4'h8;
         qdc_pkg::SEL_ALL: sel_mask = 4'hf;
         default: sel_mask = 4'h0;
      endcase
   end

   // Per-channel write and forced update strobes
   always_comb begin
      wr_vec  = 4'h0;
      upd_vec = 4'h0;
      if (block_done) begin
         case (cmd)
            qdc_pkg::QDC_CMD_WRITE_IN: begin
               wr_vec = sel_mask;
            end
            qdc_pkg::QDC_CMD_UPDATE_OUT: begin
               upd_vec = sel_mask;
            end
            qdc_pkg::QDC_CMD_WRITE_ALL: begin
               wr_vec  = sel_mask;
               upd_vec = 4'hf;
            end
            qdc_pkg::QDC_CMD_WRITE_UPD: begin
               wr_vec  = sel_mask;
               upd_vec = sel_mask;
            end
            default: begin
               wr_vec  = 4'h0;
               upd_vec = 4'h0;
            end
         endcase
      end
   end

   // Load pin low; the channel mask is ORed in at each channel
   assign load_low = !load_outputs_n_i;

   // ==========================================
   // Channel banks
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         qdc_chan u_chan (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i && !soft_reset_o),
            .wr_i    (wr_vec[g]),
            .code_i  (word[15:0]),
            .upd_i   (upd_vec[g]),
            .load_i  (load_low || load_mask_o[g]),
            .in_o    (input_code_o[g*16 +: 16]),
            .out_o   (dac_code_o[g*16 +: 16]),
            .fresh_o (fresh_vec[g])
         );
      end
   endgenerate

   // ==========================================
   // Special command registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         load_mask_o <= qdc_pkg::MASK_RESET;
      end else if (block_done && cmd == qdc_pkg::QDC_CMD_LOAD_MASK) begin
         load_mask_o <= word[3:0];
      end
   end

   // Power mode per channel, two bits each
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         power_mode_o <= 8'h00;
      end else if (block_done && cmd == qdc_pkg::QDC_CMD_POWER) begin
         for (int i = 0; i < 4; i++) begin
            if (word[i]) begin
               power_mode_o[i*2 +: 2] <= word[5:4];
            end
         end
      end
   end

   // Reference enable
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reference_on_o <= 1'b0;
      end else if (block_done && cmd == qdc_pkg::QDC_CMD_REFERENCE) begin
         reference_on_o <= word[0];
      end
   end

   // Software reset pulse, one cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         soft_reset_o <= 1'b0;
      end else begin
         soft_reset_o <= block_done && (cmd == qdc_pkg::QDC_CMD_RESET);
      end
   end

   // Last executed command
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         last_cmd_o <= 3'h0;
      end else if (block_done) begin
         last_cmd_o <= cmd;
      end
   end
endmodule

/* rtl/qdc_pkg.sv */
package qdc_pkg;
   // ==========================================
   // Word layout
   localparam int unsigned WORD_W       = 24;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned NUM_CH       = 4;
   localparam int unsigned BIT_RSVD     = 23;
   localparam int unsigned BIT_BYTEMODE = 22;
   localparam int unsigned CMD_HI       = 21;
   localparam int unsigned CMD_LO       = 19;
   localparam int unsigned SEL_HI       = 18;
   localparam int unsigned SEL_LO       = 16;
   // ==========================================
   // Addresses and reset values
   localparam logic [6:0]  BCAST_ADDR   = 7'h08;
   localparam logic [15:0] CODE_RESET   = 16'h0000;
   localparam logic [3:0]  MASK_RESET   = 4'h0;
   localparam logic [1:0]  PD_RESET     = 2'h0;
   // ==========================================
   // Commands
   typedef enum logic [2:0] {
      QDC_CMD_WRITE_IN    = 3'h0,
      QDC_CMD_UPDATE_OUT  = 3'h1,
      QDC_CMD_WRITE_ALL   = 3'h2,
      QDC_CMD_WRITE_UPD   = 3'h3,
      QDC_CMD_POWER       = 3'h4,
      QDC_CMD_RESET       = 3'h5,
      QDC_CMD_LOAD_MASK   = 3'h6,
      QDC_CMD_REFERENCE   = 3'h7
   } qdc_cmd_t;
   localparam logic [2:0] SEL_ALL = 3'h7;
endpackage

/* rtl/qdc_chan.sv */
module qdc_chan (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] code_i,
   input  wire logic        upd_i,
   input  wire logic        load_i,
   output logic [15:0]      in_o,
   output logic [15:0]      out_o,
   output logic             fresh_o
);
   // ==========================================
   // Input register, written on finished block
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         in_o <= qdc_pkg::CODE_RESET;
      end else if (wr_i) begin
         in_o <= code_i;
      end
   end

   // Fresh flag: set by write wins over clear by update
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fresh_o <= 1'b0;
      end else if (wr_i) begin
         fresh_o <= 1'b1;
      end else if (upd_i || (load_i && fresh_o)) begin
         fresh_o <= 1'b0;
      end
   end

   // Output register: forced update, or load pin while fresh
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         out_o <= qdc_pkg::CODE_RESET;
      end else if (wr_i && upd_i) begin
         out_o <= code_i;
      end else if (upd_i || (load_i && fresh_o)) begin
         out_o <= in_o;
      end
   end
endmodule

/* test/qdc_chk.sv */
module qdc_chk (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        start_i,
   input wire logic        stop_i,
   input wire logic        byte_valid_i,
   input wire logic [7:0]  byte_i,
   input wire logic [6:0]  own_addr_i,
   input wire logic        load_outputs_n_i,
   input wire logic        ack_o,
   input wire logic [63:0] dac_code_o,
   input wire logic [63:0] input_code_o,
   input wire logic [3:0]  load_mask_o,
   input wire logic        reference_on_o,
   input wire logic        soft_reset_o,
   input wire logic [2:0]  last_cmd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_ack;
      ack_o |-> byte_valid_i;
   endproperty
   a_ack: assert property (p_ack) else $error("ack without a byte");
   property p_bcast;
      start_i ##1 (byte_valid_i && byte_i == 8'h10 && !start_i && !stop_i) |-> ack_o;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast not acked");
   property p_rd;
      start_i ##1 (byte_valid_i && byte_i == 8'h11 && !start_i && !stop_i) |-> !ack_o;
   endproperty
   a_rd: assert property (p_rd) else $error("broadcast read acked");
   property p_own;
      start_i ##1 (byte_valid_i && byte_i == {own_addr_i, 1'b0} && !start_i && !stop_i)
         |-> ack_o;
   endproperty
   a_own: assert property (p_own) else $error("own address write not acked");
   property p_out_a;
      $changed(dac_code_o[15:0]) |-> dac_code_o[15:0] == input_code_o[15:0];
   endproperty
   a_out_a: assert property (p_out_a) else $error("output A not from input");
   property p_out_d;
      $changed(dac_code_o[63:48]) |-> dac_code_o[63:48] == input_code_o[63:48];
   endproperty
   a_out_d: assert property (p_out_d) else $error("output D not from input");
   property p_hold;
      $changed(dac_code_o) && load_outputs_n_i && $past(load_outputs_n_i)
         && $past(load_mask_o) == 4'h0
         |-> last_cmd_o inside {3'h1, 3'h2, 3'h3} || $past(soft_reset_o);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved with load high");
   property p_code;
      $changed(input_code_o) |-> !last_cmd_o[2] || $past(soft_reset_o);
   endproperty
   a_code: assert property (p_code) else $error("special command wrote a code");
   property p_pulse;
      soft_reset_o |=> !soft_reset_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("soft reset too long");
   property p_clr;
      soft_reset_o |=> input_code_o == 64'h0 && dac_code_o == 64'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("soft reset left codes");
   property p_ref;
      $changed(reference_on_o) |-> last_cmd_o == 3'h7;
   endproperty
   a_ref: assert property (p_ref) else $error("reference moved");
endmodule
bind qdc_top qdc_chk i_chk (.clk_i, .rst_n_i, .start_i, .stop_i, .byte_valid_i, .byte_i,
   .own_addr_i, .load_outputs_n_i, .ack_o, .dac_code_o, .input_code_o, .load_mask_o,
   .reference_on_o, .soft_reset_o, .last_cmd_o);

/* test/qdc_mst_model.sv */
module qdc_mst_model (
   input  wire logic clk_i,
   input  wire logic ack_i,
   output logic      start_o,
   output logic      stop_o,
   output logic      byte_valid_o,
   output logic [7:0] byte_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ack_q;
   // Idle lines at time zero
   initial begin
      start_o = 1'b0;
      stop_o = 1'b0;
      byte_valid_o = 1'b0;
      byte_o = 8'h00;
   end
   // One byte held valid across a rising edge; back to back allowed
   task automatic put(input logic [7:0] b);
      byte_o = b;
      byte_valid_o = 1'b1;
      @(posedge clk_i);
      ack_q = ack_i;
      @(negedge clk_i);
   endtask
   // Start pulse, then the address byte
   task automatic begin_frame(input logic [7:0] a);
      start_o = 1'b1;
      @(negedge clk_i);
      start_o = 1'b0;
      put(a);
   endtask
   // Release the byte lines, inverted, and end the stream with stop
   task automatic end_frame();
      byte_valid_o = 1'b0;
      byte_o = ~byte_o;
      stop_o = 1'b1;
      @(negedge clk_i);
      stop_o = 1'b0;
   endtask
endmodule

/* test/test_quad_dac_command_update.sv */
module test_quad_dac_command_update;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, load_n, start, stop, bv, ack, ref_on, srst;
   logic [7:0]  byte_d, pwr;
   logic [63:0] dac, inc;
   logic [3:0]  mask;
   logic [2:0]  lcmd;
   logic [6:0]  own;
   int          n_errors, checks_done, cycles;
   // ==========
   // Design and bus master
   qdc_top i_dut (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .stop_i(stop),
      .byte_valid_i(bv), .byte_i(byte_d), .own_addr_i(own), .load_outputs_n_i(load_n),
      .ack_o(ack), .dac_code_o(dac), .input_code_o(inc), .load_mask_o(mask),
      .power_mode_o(pwr), .reference_on_o(ref_on), .soft_reset_o(srst), .last_cmd_o(lcmd));
   qdc_mst_model i_mst (.clk_i(clk), .ack_i(ack), .start_o(start), .stop_o(stop),
      .byte_valid_o(bv), .byte_o(byte_d));
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ==========
   // Tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chan(input int n, input logic [15:0] ei, input logic [15:0] eo);
      chk("input code", ei, inc[n*16 +: 16]);
      chk("output code", eo, dac[n*16 +: 16]);
   endtask
   task automatic blk(input logic s, input logic [2:0] c, input logic [2:0] a,
                      input logic [15:0] d);
      i_mst.put({1'b0, s, c, a});
      i_mst.put(d[15:8]);
      i_mst.put(d[7:0]);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [2:0] c, input logic [2:0] a,
                     input logic [15:0] d);
      i_mst.begin_frame(ad);
      blk(1'b0, c, a, d);
      i_mst.end_frame();
      repeat (2) @(negedge clk);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         close_out();
      end
   end
   // ==========
   // Tests
   initial begin
      rst_n = 1'b0;
      load_n = 1'b1;
      own = 7'h0c;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      for (int n = 0; n < 4; n++) chan(n, 16'h0000, 16'h0000);
      wr(8'h18, 3'h0, 3'h1, 16'h1234);
      chan(1, 16'h1234, 16'h0000);
      load_n = 1'b0;
      repeat (2) @(negedge clk);
      chan(1, 16'h1234, 16'h1234);
      wr(8'h18, 3'h0, 3'h2, 16'h5555);
      chan(2, 16'h5555, 16'h5555);
      load_n = 1'b1;
      $display("test load done");
      wr(8'h18, 3'h0, 3'h3, 16'h0abc);
      wr(8'h18, 3'h2, 3'h0, 16'h0f0f);
      chan(0, 16'h0f0f, 16'h0f0f);
      chan(3, 16'h0abc, 16'h0abc);
      wr(8'h18, 3'h0, 3'h1, 16'h7777);
      wr(8'h18, 3'h1, 3'h1, 16'hffff);
      chan(1, 16'h7777, 16'h7777);
      wr(8'h18, 3'h3, 3'h7, 16'h4242);
      for (int n = 0; n < 4; n++) chan(n, 16'h4242, 16'h4242);
      wr(8'h18, 3'h3, 3'h5, 16'h9999);
      for (int n = 0; n < 4; n++) chan(n, 16'h4242, 16'h4242);
      $display("test commands done");
      i_mst.begin_frame(8'h18);
      i_mst.put(8'h58);
      repeat (2) i_mst.put(8'h11);
      repeat (2) i_mst.put(8'h22);
      i_mst.put(8'h33);
      i_mst.end_frame();
      repeat (2) @(negedge clk);
      chan(0, 16'h2222, 16'h2222);
      i_mst.begin_frame(8'h18);
      blk(1'b0, 3'h3, 3'h1, 16'h3333);
      blk(1'b0, 3'h3, 3'h2, 16'h4444);
      i_mst.end_frame();
      repeat (2) @(negedge clk);
      chan(1, 16'h3333, 16'h3333);
      chan(2, 16'h4444, 16'h4444);
      $display("test stream done");
      wr(8'h10, 3'h3, 3'h3, 16'h5a5a);
      chan(3, 16'h5a5a, 16'h5a5a);
      wr(8'h11, 3'h3, 3'h3, 16'h0001);
      chk("ack", 16'h0000, {15'h0, i_mst.ack_q});
      chan(3, 16'h5a5a, 16'h5a5a);
      own = 7'h0d;
      wr(8'h18, 3'h3, 3'h3, 16'h1111);
      chk("ack", 16'h0000, {15'h0, i_mst.ack_q});
      chan(3, 16'h5a5a, 16'h5a5a);
      wr(8'h10, 3'h3, 3'h2, 16'h2121);
      chk("ack", 16'h0001, {15'h0, i_mst.ack_q});
      chan(2, 16'h2121, 16'h2121);
      wr(8'h1a, 3'h3, 3'h1, 16'h1a1a);
      chk("ack", 16'h0001, {15'h0, i_mst.ack_q});
      chan(1, 16'h1a1a, 16'h1a1a);
      own = 7'h0c;
      $display("test broadcast done");
      wr(8'h18, 3'h7, 3'h0, 16'h0001);
      chk("reference", 16'h0001, {15'h0, ref_on});
      wr(8'h18, 3'h6, 3'h0, 16'h0005);
      chk("load mask", 16'h0005, {12'h0, mask});
      wr(8'h18, 3'h4, 3'h0, 16'h0031);
      chk("power", 16'h0003, {14'h0, pwr[1:0]});
      wr(8'h18, 3'h5, 3'h0, 16'h0000);
      chan(3, 16'h0000, 16'h0000);
      $display("test special done");
      close_out();
   end
endmodule
